// ===== logic/awt_regs.svh
`ifndef AWT_REGS_SVH
`define AWT_REGS_SVH

// register indices on the plain register port
`define AWT_ADDR_CTRL 4'h0
`define AWT_ADDR_STATUS 4'h1
`define AWT_ADDR_CFG_PITCH 4'h2
`define AWT_ADDR_CFG_ROLL 4'h3
`define AWT_ADDR_CFG_PRATE 4'h4
`define AWT_ADDR_CFG_RRATE 4'h5
`define AWT_ADDR_PITCH_ANGLE 4'h6
`define AWT_ADDR_ROLL_ANGLE 4'h7
`define AWT_ADDR_PITCH_RATE 4'h8
`define AWT_ADDR_ROLL_RATE 4'h9

// control fields
`define AWT_CTRL_EN 0
`define AWT_CTRL_CHAN 1
`define AWT_CTRL_RATE_LSB 2
`define AWT_CTRL_RATE_MSB 3

// word configuration fields
`define AWT_CFG_LABEL_LSB 0
`define AWT_CFG_LABEL_MSB 7
`define AWT_CFG_MATRIX_LSB 8
`define AWT_CFG_MATRIX_MSB 9
`define AWT_CFG_PARITY 10

// status fields
`define AWT_STAT_BUSY 0
`define AWT_STAT_WORD_LSB 1
`define AWT_STAT_WORD_MSB 2
`define AWT_STAT_PITCH_TO 3
`define AWT_STAT_ROLL_TO 4
`define AWT_STAT_PENDING 5

// reset values
`define AWT_RST_LABEL 8'h00
`define AWT_RST_ANGLE 15'h0000
`define AWT_RST_RATE 9'h000

// timing
`define AWT_CLK_PERIOD_NS 4
`define AWT_BIT_PERIOD_NS 80600
`define AWT_INTERVAL_20_US 50000
`define AWT_INTERVAL_100_US 10000
`define AWT_INTERVAL_150_US 6670
`define AWT_ANGLE_TIMEOUT_MS 1000

`endif

// ===== logic/awt_pkg.sv
package awt_pkg;

    typedef enum logic [0:0] {
        AWT_IDLE = 1'b0,
        AWT_SEND = 1'b1
    } awt_tx_state_t;

    typedef enum logic [1:0] {
        AWT_W_PITCH = 2'b00,
        AWT_W_ROLL = 2'b01,
        AWT_W_PRATE = 2'b10,
        AWT_W_RRATE = 2'b11
    } awt_word_t;

    typedef enum logic [1:0] {
        AWT_RATE_20 = 2'b00,
        AWT_RATE_100 = 2'b01,
        AWT_RATE_150 = 2'b10
    } awt_rate_sel_t;

    // bit 0 goes to word bit 30, bit 1 to word bit 31
    typedef enum logic [1:0] {
        AWT_MX_WARNING = 2'b00,
        AWT_MX_SECOND_STATUS = 2'b01,
        AWT_MX_FUNCTIONAL_CHECK = 2'b10,
        AWT_MX_NORMAL_OPERATION = 2'b11
    } awt_matrix_t;

    typedef struct packed {
        logic armed;
        logic [31:0] cnt;
        logic expire;
    } awt_to_state_t;

    typedef struct packed {
        awt_tx_state_t state;
        logic en;
        logic chanSel;
        logic [1:0] rateSel;
        logic [3:0][7:0] label;
        logic [3:0][1:0] matrix;
        logic [3:0] parOdd;
        logic [14:0] pitchAngle;
        logic [14:0] rollAngle;
        logic [8:0] pitchRate;
        logic [8:0] rollRate;
        logic [1:0] toFlag;
        logic [31:0] intervalCnt;
        logic pending;
        logic [31:0] bitTimer;
        logic [4:0] bitIdx;
        logic [1:0] wordIdx;
        logic [31:0] shift;
        logic txChan;
        logic [1:0] hi;
        logic [1:0] lo;
        logic [31:0] rdata;
    } awt_top_state_t;

endpackage

// ===== logic/awt_word_if.sv
`timescale 1ns/1ns
interface awt_word_if;
    logic isRate;
    logic [7:0] label;
    logic [1:0] matrix;
    logic parityOdd;
    logic [14:0] angle;
    logic [8:0] rate;
    logic [31:0] word;

    modport src(output isRate, output label, output matrix, output parityOdd,
                output angle, output rate, input word);
    modport bld(input isRate, input label, input matrix, input parityOdd,
                input angle, input rate, output word);
endinterface

// ===== logic/awt_word_builder.sv
`timescale 1ns/1ns
module awt_word_builder (
    awt_word_if.bld fi // word fields in, assembled word out
);
    logic [31:0] w;

    always_comb begin
        w = '0;
        for (int i = 0; i < 8; i++) begin
            w[i] = fi.label[7 - i];
        end
        if (fi.isRate) begin
            w[28:20] = fi.rate;
        end else begin
            w[28:14] = fi.angle;
        end
        w[29] = fi.matrix[0];
        w[30] = fi.matrix[1];
        // odd parity makes the whole word hold an odd count of ones
        w[31] = fi.parityOdd ? ~(^w[30:0]) : (^w[30:0]);
    end

    assign fi.word = w;
endmodule

// ===== logic/awt_timeout.sv
`timescale 1ns/1ns
module awt_timeout #(
    parameter int unsigned CYC = 250000000
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic reload, // angle freshly written
    output logic expire // one-cycle pulse when the angle goes stale
);
    awt_pkg::awt_to_state_t s;
    awt_pkg::awt_to_state_t n;

    always_comb begin
        n = s;
        n.expire = 1'b0;
        if (reload) begin
            n.armed = 1'b1;
            n.cnt = '0;
        end else if (s.armed) begin
            if (s.cnt == CYC - 1) begin
                n.armed = 1'b0;
                n.expire = 1'b1;
            end else begin
                n.cnt = s.cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign expire = s.expire;
endmodule

// ===== logic/attitude_word_transmitter.sv
`timescale 1ns/1ns
`include "awt_regs.svh"
// Operation
// - while enabled, repeat a group of pitch, roll, pitch rate, roll rate words
// - rate setting 20 gives 50 ms between like words; 100 and 150 (10, 6.67 ms) are shorter than a 128-bit group, so groups run back to back
// - bits 30 and 31 carry the status matrix code
// - angle words carry two's complement angle in bits 15 to 29
// - bits 1 to 8 carry the octal label, label MSB in bit 1
// - angle words hold bits 9 to 14 low
// - rate words hold bits 9 to 20 low
// - bit 32 gives odd or even parity over the whole word
// - rate words carry two's complement rate in bits 21 to 29
// - rate returns to zero when its axis angle times out
// - transmit condition off stops all words, bus idle
// - channel select routes the word stream to channel 0 or 1
module attitude_word_transmitter #(
    parameter int unsigned BIT_CYC = `AWT_BIT_PERIOD_NS / `AWT_CLK_PERIOD_NS,
    parameter int unsigned INT20_CYC = `AWT_INTERVAL_20_US * 1000 / `AWT_CLK_PERIOD_NS,
    parameter int unsigned INT100_CYC = `AWT_INTERVAL_100_US * 1000 / `AWT_CLK_PERIOD_NS,
    parameter int unsigned INT150_CYC = `AWT_INTERVAL_150_US * 1000 / `AWT_CLK_PERIOD_NS,
    parameter int unsigned TIMEOUT_CYC =
        `AWT_ANGLE_TIMEOUT_MS * 1000000 / `AWT_CLK_PERIOD_NS
) (
    input wire logic clk, // 250 MHz system clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic [3:0] regAddr, // register index
    input wire logic [31:0] regWdata, // write data
    input wire logic regWr, // write strobe
    input wire logic regRd, // read strobe
    output logic [31:0] regRdata, // read data, cycle after strobe
    output logic [1:0] lineHi, // per channel: high half of a one bit
    output logic [1:0] lineLo, // per channel: high half of a zero bit
    output logic txActive // group in progress
);
    awt_pkg::awt_top_state_t s;
    awt_pkg::awt_top_state_t n;

    logic pitchExpire;
    logic rollExpire;
    logic pitchReload;
    logic rollReload;
    logic [1:0] buildSel;
    logic [31:0] intervalLast;

    awt_word_if wordIf ();

    awt_word_builder u_builder (
        .fi(wordIf.bld)
    );

    awt_timeout #(.CYC(TIMEOUT_CYC)) u_pitch_to (
        .clk(clk),
        .sys_rst(sys_rst),
        .reload(pitchReload),
        .expire(pitchExpire)
    );

    awt_timeout #(.CYC(TIMEOUT_CYC)) u_roll_to (
        .clk(clk),
        .sys_rst(sys_rst),
        .reload(rollReload),
        .expire(rollExpire)
    );

    assign pitchReload = regWr && (regAddr == `AWT_ADDR_PITCH_ANGLE);
    assign rollReload = regWr && (regAddr == `AWT_ADDR_ROLL_ANGLE);

    // the builder always prepares the word that the shifter loads next
    assign buildSel = (s.state == awt_pkg::AWT_IDLE) ? 2'b00 : 2'(s.wordIdx + 2'b01);

    always_comb begin
        wordIf.isRate = buildSel[1];
        wordIf.label = s.label[buildSel];
        wordIf.matrix = s.matrix[buildSel];
        wordIf.parityOdd = s.parOdd[buildSel];
        wordIf.angle = buildSel[0] ? s.rollAngle : s.pitchAngle;
        wordIf.rate = buildSel[0] ? s.rollRate : s.pitchRate;
    end

    always_comb begin
        case (s.rateSel)
            awt_pkg::AWT_RATE_100: intervalLast = INT100_CYC - 1;
            awt_pkg::AWT_RATE_150: intervalLast = INT150_CYC - 1;
            default: intervalLast = INT20_CYC - 1;
        endcase
    end

    always_comb begin
        n = s;
        n.rdata = '0;

        // stale angle drops its rate back to zero
        if (pitchExpire) begin
            n.pitchRate = `AWT_RST_RATE;
        end
        if (rollExpire) begin
            n.rollRate = `AWT_RST_RATE;
        end

        if (regWr) begin
            case (regAddr)
                `AWT_ADDR_CTRL: begin
                    n.en = regWdata[`AWT_CTRL_EN];
                    n.chanSel = regWdata[`AWT_CTRL_CHAN];
                    n.rateSel = regWdata[`AWT_CTRL_RATE_MSB:`AWT_CTRL_RATE_LSB];
                end
                `AWT_ADDR_CFG_PITCH, `AWT_ADDR_CFG_ROLL,
                `AWT_ADDR_CFG_PRATE, `AWT_ADDR_CFG_RRATE: begin
                    n.label[regAddr[1:0] - 2'b10] =
                        regWdata[`AWT_CFG_LABEL_MSB:`AWT_CFG_LABEL_LSB];
                    n.matrix[regAddr[1:0] - 2'b10] =
                        regWdata[`AWT_CFG_MATRIX_MSB:`AWT_CFG_MATRIX_LSB];
                    n.parOdd[regAddr[1:0] - 2'b10] = regWdata[`AWT_CFG_PARITY];
                end
                `AWT_ADDR_PITCH_ANGLE: begin
                    n.pitchAngle = regWdata[14:0];
                    n.toFlag[0] = 1'b0;
                end
                `AWT_ADDR_ROLL_ANGLE: begin
                    n.rollAngle = regWdata[14:0];
                    n.toFlag[1] = 1'b0;
                end
                // a fresh rate from software outranks a timeout in the same cycle
                `AWT_ADDR_PITCH_RATE: n.pitchRate = regWdata[8:0];
                `AWT_ADDR_ROLL_RATE: n.rollRate = regWdata[8:0];
                default: begin
                end
            endcase
        end

        // set wins over the clear done by an angle write
        if (pitchExpire) begin
            n.toFlag[0] = 1'b1;
        end
        if (rollExpire) begin
            n.toFlag[1] = 1'b1;
        end

        if (regRd) begin
            case (regAddr)
                `AWT_ADDR_CTRL: begin
                    n.rdata[`AWT_CTRL_EN] = s.en;
                    n.rdata[`AWT_CTRL_CHAN] = s.chanSel;
                    n.rdata[`AWT_CTRL_RATE_MSB:`AWT_CTRL_RATE_LSB] = s.rateSel;
                end
                `AWT_ADDR_STATUS: begin
                    n.rdata[`AWT_STAT_BUSY] = (s.state == awt_pkg::AWT_SEND);
                    n.rdata[`AWT_STAT_WORD_MSB:`AWT_STAT_WORD_LSB] = s.wordIdx;
                    n.rdata[`AWT_STAT_PITCH_TO] = s.toFlag[0];
                    n.rdata[`AWT_STAT_ROLL_TO] = s.toFlag[1];
                    n.rdata[`AWT_STAT_PENDING] = s.pending;
                end
                `AWT_ADDR_CFG_PITCH, `AWT_ADDR_CFG_ROLL,
                `AWT_ADDR_CFG_PRATE, `AWT_ADDR_CFG_RRATE: begin
                    n.rdata[`AWT_CFG_LABEL_MSB:`AWT_CFG_LABEL_LSB] =
                        s.label[regAddr[1:0] - 2'b10];
                    n.rdata[`AWT_CFG_MATRIX_MSB:`AWT_CFG_MATRIX_LSB] =
                        s.matrix[regAddr[1:0] - 2'b10];
                    n.rdata[`AWT_CFG_PARITY] = s.parOdd[regAddr[1:0] - 2'b10];
                end
                `AWT_ADDR_PITCH_ANGLE: n.rdata[14:0] = s.pitchAngle;
                `AWT_ADDR_ROLL_ANGLE: n.rdata[14:0] = s.rollAngle;
                `AWT_ADDR_PITCH_RATE: n.rdata[8:0] = s.pitchRate;
                `AWT_ADDR_ROLL_RATE: n.rdata[8:0] = s.rollRate;
                default: n.rdata = '0;
            endcase
        end

        // group pacing; disabled means the first group goes out at once on enable
        if (!s.en) begin
            n.intervalCnt = '0;
            n.pending = 1'b1;
        end else if (s.intervalCnt >= intervalLast) begin
            n.intervalCnt = '0;
            n.pending = 1'b1;
        end else begin
            n.intervalCnt = s.intervalCnt + 32'h1;
        end

        case (s.state)
            awt_pkg::AWT_IDLE: begin
                if (s.en && s.pending) begin
                    n.state = awt_pkg::AWT_SEND;
                    n.pending = 1'b0;
                    n.wordIdx = 2'b00;
                    n.bitIdx = 5'h00;
                    n.bitTimer = '0;
                    n.shift = wordIf.word;
                    // channel is latched per group so a word never splits
                    n.txChan = s.chanSel;
                end
            end
            awt_pkg::AWT_SEND: begin
                if (!s.en) begin
                    n.state = awt_pkg::AWT_IDLE;
                end else if (s.bitTimer == BIT_CYC - 1) begin
                    n.bitTimer = '0;
                    if (s.bitIdx == 5'h1f) begin
                        n.bitIdx = 5'h00;
                        if (s.wordIdx == 2'b11) begin
                            n.state = awt_pkg::AWT_IDLE;
                        end else begin
                            n.wordIdx = 2'(s.wordIdx + 2'b01);
                            n.shift = wordIf.word;
                        end
                    end else begin
                        n.bitIdx = 5'(s.bitIdx + 5'h01);
                        n.shift = {1'b0, s.shift[31:1]};
                    end
                end else begin
                    n.bitTimer = s.bitTimer + 32'h1;
                end
            end
            default: begin
                n.state = awt_pkg::AWT_IDLE;
            end
        endcase

        // return-to-zero line: first half of each bit marks its value, then null
        n.hi = 2'b00;
        n.lo = 2'b00;
        if (n.state == awt_pkg::AWT_SEND && n.bitTimer < BIT_CYC / 2) begin
            n.hi[n.txChan] = n.shift[0];
            n.lo[n.txChan] = ~n.shift[0];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign regRdata = s.rdata;
    assign lineHi = s.hi;
    assign lineLo = s.lo;
    assign txActive = (s.state == awt_pkg::AWT_SEND);
endmodule

// ===== tb/awt_checker.sv
`timescale 1ns/1ns
module awt_checker #(
    parameter int unsigned BIT_CYC = 8
) (
    input wire logic clk, // clock
    input wire logic sys_rst, // reset
    input wire logic [3:0] regAddr, // index
    input wire logic [31:0] regWdata, // wdata
    input wire logic regWr, // write
    input wire logic regRd, // read
    input wire logic [31:0] regRdata, // rdata
    input wire logic [1:0] lineHi, // one halves
    input wire logic [1:0] lineLo, // zero halves
    input wire logic txActive // busy
);
    localparam int GL = 128 * BIT_CYC;
    logic [1:0] act;
    logic actRise;
    logic actPrev_reg;
    logic enSh_reg;
    logic chSh_reg;
    // wide enough for full-length bit periods and groups
    logic [31:0] since_reg;
    logic [31:0] grp_reg;
    assign act = lineHi | lineLo;
    assign actRise = (|act) && !actPrev_reg;
    // shadows of the control word, only written by the bus
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            actPrev_reg <= 1'b0;
            enSh_reg <= 1'b0;
            chSh_reg <= 1'b0;
            since_reg <= 32'hffffffff;
            grp_reg <= 32'h0;
        end else begin
            actPrev_reg <= |act;
            if (regWr && regAddr == 4'h0) begin
                enSh_reg <= regWdata[0];
                chSh_reg <= regWdata[1];
            end
            since_reg <= actRise ? 32'h0 : (&since_reg ? since_reg : since_reg + 32'h1);
            grp_reg <= txActive ? grp_reg + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_excl; (lineHi & lineLo) == 2'b00; endproperty
    a_excl: assert property (p_excl) else $error("one and zero together");
    property p_oneChan; act != 2'b11; endproperty
    a_oneChan: assert property (p_oneChan) else $error("both channels busy");
    property p_enStart;
        regWr && regAddr == 4'h0 && regWdata[0] && !enSh_reg && !txActive |-> ##2 txActive;
    endproperty
    a_enStart: assert property (p_enStart) else $error("group did not start");
    property p_route; $rose(txActive) |=> act == (chSh_reg ? 2'b10 : 2'b01); endproperty
    a_route: assert property (p_route) else $error("wrong channel");
    property p_off;
        regWr && regAddr == 4'h0 && !regWdata[0] |-> ##3 (act == 2'b00 && !txActive) [*8];
    endproperty
    a_off: assert property (p_off) else $error("bus not idle after off");
    property p_half; $fell(|act) && txActive |-> since_reg == BIT_CYC / 2 - 1; endproperty
    a_half: assert property (p_half) else $error("bit half wrong");
    property p_space; actRise |-> since_reg >= BIT_CYC - 1; endproperty
    a_space: assert property (p_space) else $error("bits too close");
    property p_grpLen;
        $fell(txActive) && enSh_reg |-> grp_reg >= GL && grp_reg <= GL + 1;
    endproperty
    a_grpLen: assert property (p_grpLen) else $error("group length wrong");
    property p_gap; $fell(txActive) && enSh_reg |-> act == 2'b00 ##1 act == 2'b00; endproperty
    a_gap: assert property (p_gap) else $error("no gap between groups");
    c_group: cover property ($fell(txActive) && enSh_reg);
    c_chan1: cover property ($rose(txActive) ##1 act == 2'b10);
    c_abort: cover property ($fell(txActive) && !enSh_reg);
endmodule
bind attitude_word_transmitter awt_checker #(.BIT_CYC(BIT_CYC)) chk_u (.clk(clk),
    .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .lineHi(lineHi), .lineLo(lineLo),
    .txActive(txActive));

// ===== tb/awt_rx_model.sv
`timescale 1ns/1ns
module awt_rx_model (
    input wire logic clk, // clock
    input wire logic [1:0] lineHi, // one halves
    input wire logic [1:0] lineLo // zero halves
);
    logic [31:0] sh [2];
    int n [2] = '{0, 0};
    int q [2] = '{1, 1};
    logic [31:0] wq [$];
    int cq [$];
    longint tq [$];
    // a cut-off word is dropped after a quiet spell
    always @(posedge clk) begin
        for (int c = 0; c < 2; c++) begin
            if (lineHi[c] || lineLo[c]) begin
                if (q[c] > 0) begin
                    sh[c] = {lineHi[c], sh[c][31:1]};
                    n[c]++;
                end
                q[c] = 0;
            end else begin
                q[c]++;
                if (q[c] > 64) n[c] = 0;
            end
            if (n[c] == 32) begin
                wq.push_back(sh[c]);
                cq.push_back(c);
                tq.push_back($time);
                n[c] = 0;
            end
        end
    end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    localparam int I20 = 1500;
    localparam int I100 = 1200;
    localparam int I150 = 1100;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdata;
    logic [1:0] lineHi;
    logic [1:0] lineLo;
    logic txActive;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [7:0] lbl [4] = '{8'hff, 8'haa, 8'h55, 8'h00};
    logic [1:0] mx [4] = '{2'b11, 2'b01, 2'b10, 2'b00};
    logic od [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [14:0] dat [4] = '{15'h0, 15'h0, 15'h1ff, 15'h0ab};
    logic [1:0] rs [3] = '{2'b01, 2'b10, 2'b00};
    int per [3] = '{I100, I150, I20};
    logic [31:0] d;
    longint t1;
    longint t2;
    longint tt;
    always #2 clk = ~clk;
    attitude_word_transmitter #(.BIT_CYC(8), .INT20_CYC(I20), .INT100_CYC(I100),
        .INT150_CYC(I150), .TIMEOUT_CYC(50)) dut_u (.clk(clk), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .lineHi(lineHi), .lineLo(lineLo), .txActive(txActive));
    awt_rx_model rx_u (.clk(clk), .lineHi(lineHi), .lineLo(lineLo));
    task automatic wrap_up();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        v = regRdata;
    endtask
    // word as received, index 0 is the first bit on the line
    function automatic logic [31:0] mk(input int k);
        logic [31:0] w;
        w = 32'h0;
        for (int i = 0; i < 8; i++) w[i] = lbl[k][7 - i];
        for (int i = 0; i < 15; i++) begin
            if (k < 2) w[14 + i] = dat[k][i];
            else if (i < 9) w[20 + i] = dat[k][i];
        end
        w[30:29] = mx[k];
        w[31] = (^w[30:0]) ^ od[k];
        return w;
    endfunction
    task automatic clr();
        rx_u.wq.delete();
        rx_u.cq.delete();
        rx_u.tq.delete();
    endtask
    task automatic getw(input int k, input logic [31:0] ch, output longint t);
        while (rx_u.wq.size() == 0) @(posedge clk);
        t = rx_u.tq.pop_front();
        chk(rx_u.wq.pop_front(), mk(k));
        chk(32'(rx_u.cq.pop_front()), ch);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(4'h1, d);
        // pending stands while disabled, nothing else set
        chk(d, 32'h20);
        rd(4'ha, d);
        chk(d, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(4'(2 + k), {21'h0, od[k], mx[k], lbl[k]});
            if (k > 1) wr(4'(6 + k), {23'h0, dat[k][8:0]});
        end
        foreach (rs[i]) begin
            wr(4'h0, {28'h0, rs[i], 2'b01});
            @(posedge clk);
            while (txActive !== 1'b0) @(posedge clk);
            clr();
            for (int g = 0; g < 3; g++) begin
                for (int k = 0; k < 4; k++) begin
                    getw(k, 32'h0, tt);
                    if (k == 0) begin
                        t1 = t2;
                        t2 = tt;
                    end
                end
            end
            chk(32'(t2 - t1), 32'(per[i] * 4));
        end
        while (txActive !== 1'b1) @(posedge clk);
        repeat (100) @(posedge clk);
        wr(4'h0, 32'h0);
        repeat (8) @(posedge clk);
        clr();
        repeat (1600) @(posedge clk);
        chk(32'(rx_u.wq.size()), 32'h0);
        chk({30'h0, lineHi | lineLo}, 32'h0);
        rd(4'h1, d);
        chk(d & 32'h1, 32'h0);
        wr(4'h6, 32'h1fff);
        wr(4'h7, 32'h6001);
        repeat (100) @(posedge clk);
        rd(4'h1, d);
        chk(d & 32'h18, 32'h18);
        rd(4'h8, d);
        chk(d, 32'h0);
        dat = '{15'h1fff, 15'h6001, 15'h0, 15'h0};
        wr(4'h0, 32'h3);
        for (int k = 0; k < 4; k++) getw(k, 32'h1, tt);
        wrap_up();
    end
endmodule
